// ===== logic/hbfs_ctrl.sv
/*
  Protection and sleep control for a dual H-bridge: overcurrent filter and retry per bridge,
  thermal shutdown, undervoltage lockout, fault indicator and sleep timing.
  Assumes all inputs synchronous to sys_clk; comparator flags come from analog circuitry.
*/
`timescale 1ns/1ps
`default_nettype none

module hbfs_ctrl #(
  parameter int unsigned OC_RETRY_CYCLES = hbfs_pkg::OC_RETRY_CYC
) (
  input  wire  logic       sys_clk,
  input  wire  logic       rst,
  input  wire  logic       sleep_request_low,
  input  wire  logic       supply_low,
  input  wire  logic       over_temp,
  input  wire  logic [1:0] oc_high_side,
  input  wire  logic [1:0] oc_low_side,
  output logic       [1:0] bridge_enable,
  output logic             fault_indicator_low,
  output logic             fault_indicator_oe,
  output logic             in_sleep,
  output logic             logic_enable
);

  typedef struct packed {
    hbfs_pkg::hbfs_bridge_state_t [1:0]      br;
    logic [1:0][hbfs_pkg::CNT_W-1:0]         filt;
    logic [1:0][hbfs_pkg::CNT_W-1:0]         retry;
    hbfs_pkg::hbfs_mode_t                    mode;
    logic [hbfs_pkg::CNT_W-1:0]              mcnt;
    logic                                    sleep_req_d;
    logic [1:0]                              en;
    logic                                    fault;
  } hbfs_state_t;

  localparam logic [hbfs_pkg::CNT_W-1:0] RETRY_LAST = hbfs_pkg::CNT_W'(OC_RETRY_CYCLES - 1);
  localparam logic [hbfs_pkg::CNT_W-1:0] FILT_LAST  = hbfs_pkg::CNT_W'(hbfs_pkg::OC_FILTER_CYC);
  localparam logic [hbfs_pkg::CNT_W-1:0] SLP_LAST   = hbfs_pkg::CNT_W'(hbfs_pkg::SLEEP_ENTRY_CYC - 1);
  localparam logic [hbfs_pkg::CNT_W-1:0] WAKE_LAST  = hbfs_pkg::CNT_W'(hbfs_pkg::WAKE_CYC - 1);

  hbfs_state_t st_ff;
  hbfs_state_t nxt_st;

  function automatic logic [hbfs_pkg::CNT_W-1:0] inc_sat(input logic [hbfs_pkg::CNT_W-1:0] v);
    inc_sat = (v == {hbfs_pkg::CNT_W{1'b1}}) ? v : v + hbfs_pkg::CNT_ONE;
  endfunction

  function automatic hbfs_state_t clear_state();
    hbfs_state_t s;
    s = '0;
    // Seen as high after reset so a pin already held low still enters sleep
    s.sleep_req_d = 1'b1;
    s.br   = {hbfs_pkg::HBFS_BR_RUN, hbfs_pkg::HBFS_BR_RUN};
    s.mode = hbfs_pkg::HBFS_MD_ACTIVE;
    clear_state = s;
  endfunction

  logic running;
  logic [1:0] oc_any;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.sleep_req_d = sleep_request_low;
    oc_any      = oc_high_side | oc_low_side;
    running     = (st_ff.mode == hbfs_pkg::HBFS_MD_ACTIVE) || (st_ff.mode == hbfs_pkg::HBFS_MD_ENTERING);

    // Mode sequencing
    case (st_ff.mode)
      hbfs_pkg::HBFS_MD_ACTIVE: begin
        if (!sleep_request_low && st_ff.sleep_req_d) begin
          nxt_st.mode = hbfs_pkg::HBFS_MD_ENTERING;
          nxt_st.mcnt = hbfs_pkg::CNT_ZERO;
        end
      end
      hbfs_pkg::HBFS_MD_ENTERING: begin
        if (sleep_request_low) begin
          nxt_st.mode = hbfs_pkg::HBFS_MD_ACTIVE;
        end else if (st_ff.mcnt == SLP_LAST) begin
          nxt_st.mode = hbfs_pkg::HBFS_MD_SLEEP;
        end else begin
          nxt_st.mcnt = inc_sat(st_ff.mcnt);
        end
      end
      hbfs_pkg::HBFS_MD_SLEEP: begin
        if (sleep_request_low) begin
          nxt_st.mode = hbfs_pkg::HBFS_MD_WAKING;
          nxt_st.mcnt = hbfs_pkg::CNT_ZERO;
        end
      end
      hbfs_pkg::HBFS_MD_WAKING: begin
        if (!sleep_request_low) begin
          nxt_st.mode = hbfs_pkg::HBFS_MD_SLEEP;
        end else if (st_ff.mcnt == WAKE_LAST) begin
          nxt_st.mode = hbfs_pkg::HBFS_MD_ACTIVE;
        end else begin
          nxt_st.mcnt = inc_sat(st_ff.mcnt);
        end
      end
      default: begin
        nxt_st.mode = hbfs_pkg::HBFS_MD_ACTIVE;
      end
    endcase

    // Per-bridge overcurrent; each bridge only looks at its own flags
    for (int b = 0; b < hbfs_pkg::NUM_BRIDGES; b++) begin
      case (st_ff.br[b])
        hbfs_pkg::HBFS_BR_RUN: begin
          nxt_st.retry[b] = hbfs_pkg::CNT_ZERO;
          if (oc_any[b] && running) begin
            nxt_st.filt[b] = inc_sat(st_ff.filt[b]);
            if (st_ff.filt[b] >= FILT_LAST) begin
              nxt_st.br[b]   = hbfs_pkg::HBFS_BR_RETRY;
              nxt_st.filt[b] = hbfs_pkg::CNT_ZERO;
            end
          end else begin
            nxt_st.filt[b] = hbfs_pkg::CNT_ZERO;
          end
        end
        hbfs_pkg::HBFS_BR_RETRY: begin
          if (st_ff.retry[b] == RETRY_LAST) begin
            nxt_st.br[b]    = hbfs_pkg::HBFS_BR_RUN;
            nxt_st.retry[b] = hbfs_pkg::CNT_ZERO;
          end else begin
            nxt_st.retry[b] = inc_sat(st_ff.retry[b]);
          end
        end
        default: begin
          nxt_st.br[b] = hbfs_pkg::HBFS_BR_RUN;
        end
      endcase
    end

    // Bridge drive: thermal and sleep disable everything, overcurrent only its own bridge
    for (int b = 0; b < hbfs_pkg::NUM_BRIDGES; b++) begin
      nxt_st.en[b] = (nxt_st.br[b] == hbfs_pkg::HBFS_BR_RUN) && !over_temp
                     && (nxt_st.mode == hbfs_pkg::HBFS_MD_ACTIVE);
    end
    // Fault held while either bridge is in retry or over_temp is high; sleep and undervoltage clear it
    nxt_st.fault = (nxt_st.br[0] == hbfs_pkg::HBFS_BR_RETRY) || (nxt_st.br[1] == hbfs_pkg::HBFS_BR_RETRY)
                   || over_temp;

    // Sleep stops the logic: hold everything cleared and ignore other inputs except sleep_request_low and supply_low
    if (nxt_st.mode == hbfs_pkg::HBFS_MD_SLEEP) begin
      nxt_st             = clear_state();
      nxt_st.mode        = hbfs_pkg::HBFS_MD_SLEEP;
      nxt_st.sleep_req_d = sleep_request_low;
    end
    // Undervoltage wipes all state and suppresses the fault report
    if (supply_low) begin
      nxt_st = clear_state();
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= clear_state();
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Open-drain fault: drive low when asserted, otherwise released
  assign bridge_enable       = st_ff.en;
  assign fault_indicator_low = 1'b0;
  assign fault_indicator_oe  = st_ff.fault;
  assign in_sleep            = (st_ff.mode == hbfs_pkg::HBFS_MD_SLEEP);
  assign logic_enable        = (st_ff.mode != hbfs_pkg::HBFS_MD_SLEEP) && !supply_low;

endmodule

`default_nettype wire

// ===== logic/hbfs_pkg.sv
/*
  Constants, timing and state types for the H-bridge fault and sleep controller.
  Assumes a single 100 MHz system clock.
*/
package hbfs_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Times in their own units
  localparam int unsigned OC_FILTER_NS      = 2300;
  localparam int unsigned OC_RETRY_US       = 1400;
  localparam int unsigned SLEEP_ENTRY_US    = 1;
  localparam int unsigned WAKE_US           = 1;
  // Derived cycle counts
  localparam int unsigned OC_FILTER_CYC     = (OC_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OC_RETRY_CYC      = OC_RETRY_US * CLK_MHZ;
  localparam int unsigned SLEEP_ENTRY_CYC   = SLEEP_ENTRY_US * CLK_MHZ;
  localparam int unsigned WAKE_CYC          = WAKE_US * CLK_MHZ;
  localparam int unsigned CNT_W             = 18;
  localparam int unsigned NUM_BRIDGES       = 2;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 18'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE      = 18'h00001;

  typedef enum logic [1:0] {
    HBFS_BR_RUN   = 2'b00,
    HBFS_BR_RETRY = 2'b01
  } hbfs_bridge_state_t;

  typedef enum logic [1:0] {
    HBFS_MD_ACTIVE   = 2'b00,
    HBFS_MD_ENTERING = 2'b01,
    HBFS_MD_SLEEP    = 2'b10,
    HBFS_MD_WAKING   = 2'b11
  } hbfs_mode_t;
endpackage

// ===== testbench/hbfs_ctrl_monitor.sv
/* Port checker for hbfs_ctrl. Assumes sys_clk and rst as in the design. */
`timescale 1ns/1ps
`default_nettype none
module hbfs_monitor #(parameter int unsigned OC_RETRY_CYCLES = 50) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       sleep_request_low,
  input wire logic       supply_low,
  input wire logic       over_temp,
  input wire logic [1:0] oc_high_side,
  input wire logic [1:0] oc_low_side,
  input wire logic [1:0] bridge_enable,
  input wire logic       fault_indicator_low,
  input wire logic       fault_indicator_oe,
  input wire logic       in_sleep,
  input wire logic       logic_enable
);
  logic [17:0] cnt_ff;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) cnt_ff <= 18'h00000;
    else cnt_ff <= (bridge_enable == 2'h2 && fault_indicator_oe) ? cnt_ff + 18'h00001 : 18'h00000;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence entering; $fell(sleep_request_low) ##1 !sleep_request_low [*8]; endsequence
  AST_UV: assert property (supply_low |=> bridge_enable == 2'h0 && !fault_indicator_oe) else $error("uv");
  AST_LE: assert property (supply_low |-> !logic_enable) else $error("le");
  AST_TSD: assert property (over_temp && !supply_low |=> bridge_enable == 2'h0) else $error("tsd");
  AST_SLP: assert property ($fell(sleep_request_low) |=> bridge_enable == 2'h0) else $error("slp");
  AST_DLY: assert property (entering |-> !in_sleep) else $error("dly");
  AST_HIZ: assert property (!sleep_request_low |=> bridge_enable == 2'h0) else $error("hiz");
  AST_WAKE: assert property ($rose(sleep_request_low) && in_sleep |=> bridge_enable == 2'h0 [*8]) else $error("wk");
  AST_OC: assert property ($fell(bridge_enable[0]) && bridge_enable[1] |-> fault_indicator_oe) else $error("oc");
  AST_RTY: assert property (cnt_ff <= OC_RETRY_CYCLES) else $error("rty");
  AST_FLT: assert property (fault_indicator_oe |-> bridge_enable != 2'h3 && !fault_indicator_low) else $error("f");
endmodule
bind hbfs_ctrl hbfs_monitor #(.OC_RETRY_CYCLES(OC_RETRY_CYCLES)) mon (.sys_clk, .rst, .sleep_request_low,
  .supply_low, .over_temp, .oc_high_side, .oc_low_side, .bridge_enable, .fault_indicator_low,
  .fault_indicator_oe, .in_sleep, .logic_enable);
`default_nettype wire

// ===== testbench/hbfs_stage.sv
/* Bridge stage model. Assumes bridge_enable comes from hbfs_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module hbfs_stage (
  input  wire logic [1:0] bridge_enable,
  input  wire logic [1:0] short_hs,
  input  wire logic [1:0] short_ls,
  output logic      [1:0] oc_high_side,
  output logic      [1:0] oc_low_side
);
  // Limit acts only while driving, so a held short trips again
  assign oc_high_side = short_hs & bridge_enable;
  assign oc_low_side  = short_ls & bridge_enable;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
/* Bench for hbfs_ctrl with stage model. Assumes a short retry time. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst, sleep_request_low, supply_low, over_temp, fault_indicator_low, fault_indicator_oe;
  logic in_sleep, logic_enable;
  logic [1:0] oc_high_side, oc_low_side, bridge_enable, short_hs, short_ls;
  logic [2:0] q[$];
  logic [2:0] last;
  logic [15:0] lf;
  int errors, cmp_count;
  hbfs_ctrl #(.OC_RETRY_CYCLES(50)) DUT (.sys_clk, .rst, .sleep_request_low, .supply_low, .over_temp,
    .oc_high_side, .oc_low_side, .bridge_enable, .fault_indicator_low, .fault_indicator_oe, .in_sleep, .logic_enable);
  hbfs_stage stage (.bridge_enable, .short_hs, .short_ls, .oc_high_side, .oc_low_side);
  task automatic chk(input string s, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic drain();
    for (int i = 0; i < 1000 && q.size() != 0; i++) @(posedge sys_clk);
    if (q.size() != 0) errors++;
    #1;
  endtask
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    test_done();
  end
  always @(negedge sys_clk)
    if (!rst && {bridge_enable, fault_indicator_oe} !== last) begin
      last = {bridge_enable, fault_indicator_oe};
      chk("out", {1'b0, last}, q.size() ? {1'b0, q.pop_front()} : 4'hf);
    end
  initial begin
    rst = 1'b1;
    sleep_request_low = 1'b1;
    supply_low = 1'b0;
    over_temp = 1'b0;
    short_hs = 2'h0;
    short_ls = 2'h0;
    last = 3'h0;
    lf = 16'hbd0a;
    repeat (16) @(posedge sys_clk);
    #1 rst = 0;
    q = '{3'b110};
    drain();
    for (int i = 0; i < 2; i++) begin
      q = i ? '{3'b011, 3'b110, 3'b011, 3'b110} : '{3'b101, 3'b110, 3'b101, 3'b110};
      short_hs = i ? 2'h0 : 2'h1;
      short_ls = i ? 2'h2 : 2'h0;
      repeat (230) @(posedge sys_clk);
      #1 chk("filter", {2'h0, bridge_enable}, 4'h3);
      chk("pin", {3'h0, fault_indicator_low}, 4'h0);
      drain();
      {short_hs, short_ls} = 4'h0;
    end
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    q = '{3'b001, 3'b110};
    over_temp = 1;
    repeat (4 + lf[3:0]) @(posedge sys_clk);
    #1 over_temp = 0;
    drain();
    q = '{3'b001, 3'b000, 3'b110};
    over_temp = 1;
    repeat (3) @(posedge sys_clk);
    #1 supply_low = 1;
    repeat (3) @(posedge sys_clk);
    #1 chk("uv", {fault_indicator_oe, logic_enable, bridge_enable}, 4'h0);
    {over_temp, supply_low} = 2'h0;
    drain();
    for (int k = 0; k < 2; k++) begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      q = '{3'b000, 3'b110};
      sleep_request_low = 0;
      repeat (k ? 120 : 10 + lf[5:0]) @(posedge sys_clk);
      #1 chk("sleep", {3'h0, in_sleep}, 4'(k));
      over_temp = k[0];
      repeat (5) @(posedge sys_clk);
      #1 over_temp = 0;
      sleep_request_low = 1;
      // Host waits 60*k cycles, still inside the 100-cycle wake delay, and expects drive still off
      repeat (60 * k) @(posedge sys_clk);
      #1 chk("wake", {2'h0, bridge_enable}, 4'h0);
      drain();
    end
    test_done();
  end
endmodule
`default_nettype wire
